// ===== spfs_pad_sel.sv
// One shared pad steered between a primary and an alternate function.
module spfs_pad_sel (
   // Selection
   input  wire logic          selAlt,
   // Primary function
   input  wire logic          priOut,
   input  wire logic          priOe,
   output logic               priIn,
   // Alternate function
   input  wire logic          altOut,
   input  wire logic          altOe,
   output logic               altIn,
   // Pad
   input  wire logic          padIn,
   output spfs_pkg::spfs_pad_s pad
);

   // The deselected function sees a steady zero so it cannot react to the
   // other function's traffic.
   assign pad.out = selAlt ? altOut : priOut;
   assign pad.oe  = selAlt ? altOe : priOe;
   assign priIn   = selAlt ? 1'b0 : padIn;
   assign altIn   = selAlt ? padIn : 1'b0;

endmodule // spfs_pad_sel

// ===== spfs_pin_selector.sv
// Shared pin function selector: strap latch, configuration registers and pad steering.
//
// Overview of operation
// - Strap low: pads go to audio port 1, GPIO.
// - Strap high (default): all shared pads to host.
// - Clock pad is GPIO 2 only when enabled.
// - Clock output held high unless clock enable set.
// - GPIO enable bit gates pin; direction picks output.
// - Port 0 disable moves seven pads to audio.
// - Port 1 disable moves six pads to I2C/audio.
// - Timer 0 select routes pad to data 2.
// - Timer 1 select routes pad to data 4.
// - Timer 0 input shared until data 3 drives.
// - Timer 1 input shared with transmit high clock.
// - Endian strap picks narrow data byte lane.
// - Audio port 1 pin directions from its register.
// - Host strap sampled once at reset only.
// - Configuration register bit layout, upper bits reserved.
// - Software selection bits act immediately when written.
module spfs_pin_selector (
   // Clock and reset
   input  wire logic                                 ref_clk,
   input  wire logic                                 rst_b,
   // Straps
   input  wire logic                                 host_enable_strap_pad,
   input  wire logic                                 endian_correction_strap,
   input  wire logic                                 endian_mode_strap,
   // Avalon-MM slave
   input  wire logic [7:0]                           avs_address,
   input  wire logic                                 avs_read,
   input  wire logic                                 avs_write,
   input  wire logic [31:0]                          avs_writedata,
   input  wire logic [3:0]                           avs_byteenable,
   output logic [31:0]                               avs_readdata,
   output logic                                      avs_waitrequest,
   // Host-shared pads and host port
   input  wire logic [spfs_pkg::HOST_PADS-1:0]       hostPadIn,
   output spfs_pkg::spfs_pad_s [spfs_pkg::HOST_PADS-1:0] hostPad,
   input  wire logic [spfs_pkg::HOST_PADS-1:0]       hostOut,
   input  wire logic [spfs_pkg::HOST_PADS-1:0]       hostOe,
   output logic [spfs_pkg::HOST_PADS-1:0]            hostIn,
   // Audio ports
   input  wire logic [spfs_pkg::APIN_W-1:0]          asp1Out,
   output logic [spfs_pkg::APIN_W-1:0]               asp1In,
   input  wire logic [spfs_pkg::APIN_W-1:0]          asp0Out,
   output logic [spfs_pkg::APIN_W-1:0]               asp0In,
   output logic                                      asp0MuteIn,
   output logic                                      asp1MuteIn,
   // GPIO peripheral
   input  wire logic [spfs_pkg::GPIO_W-1:0]          gpioOut,
   output logic [spfs_pkg::GPIO_W-1:0]               gpioIn,
   input  wire logic                                 gp4PadIn,
   input  wire logic                                 gp5PadIn,
   // Clock output pad
   input  wire logic                                 clkPadIn,
   output spfs_pkg::spfs_pad_s                       clkPad,
   // Serial port 0 pads
   input  wire logic [spfs_pkg::SP0_PADS-1:0]        sp0PadIn,
   output spfs_pkg::spfs_pad_s [spfs_pkg::SP0_PADS-1:0] sp0Pad,
   input  wire logic [spfs_pkg::SP0_PADS-1:0]        bsp0Out,
   input  wire logic [spfs_pkg::SP0_PADS-1:0]        bsp0Oe,
   output logic [spfs_pkg::SP0_PADS-1:0]             bsp0In,
   // Serial port 1 pads and I2C port 1
   input  wire logic [spfs_pkg::SP1_PADS-1:0]        sp1PadIn,
   output spfs_pkg::spfs_pad_s [spfs_pkg::SP1_PADS-1:0] sp1Pad,
   input  wire logic [spfs_pkg::SP1_PADS-1:0]        bsp1Out,
   input  wire logic [spfs_pkg::SP1_PADS-1:0]        bsp1Oe,
   output logic [spfs_pkg::SP1_PADS-1:0]             bsp1In,
   input  wire logic [1:0]                           i2c1DriveLow,
   output logic [1:0]                                i2c1In,
   // Timer pads
   input  wire logic                                 timer0Out,
   input  wire logic                                 timer1Out,
   output logic                                      timer0In,
   output logic                                      timer1In,
   input  wire logic                                 tmr0OutPadIn,
   input  wire logic                                 tmr1OutPadIn,
   input  wire logic                                 tmr0InPadIn,
   input  wire logic                                 tmr1InPadIn,
   output spfs_pkg::spfs_pad_s                       tmr0OutPad,
   output spfs_pkg::spfs_pad_s                       tmr1OutPad,
   output spfs_pkg::spfs_pad_s                       tmr0InPad,
   output spfs_pkg::spfs_pad_s                       tmr1InPad,
   // Memory bus configuration
   output logic                                      bigEndianLaneSel,
   output logic                                      memBusClkSrc
);

   logic [1:0]                        rstPipe_q;
   logic                              rstSync_b;
   logic                              strapDone_q;
   spfs_pkg::spfs_strap_s             strap_q;
   spfs_pkg::spfs_device_configuration_register_s            device_configuration_register_q;
   logic [spfs_pkg::GPIO_W-1:0]       gpio_enable_register_q;
   logic [spfs_pkg::GPIO_W-1:0]       gpio_direction_register_q;
   logic                              clock_output2_enable_q;
   logic [spfs_pkg::APIN_W-1:0]       apdir0_q;
   logic [spfs_pkg::APIN_W-1:0]       apdir1_q;
   logic [spfs_pkg::MUTE_W-1:0]       mute_q;
   logic                              ack_q;
   logic [31:0]                       rdData_q;
   logic                              clkDiv_q;
   logic                              busReq;
   logic                              wrTake;
   logic [31:0]                       beMask;
   logic [31:0]                       wrMerged;
   logic [31:0]                       rdMux;
   logic [spfs_pkg::GPIO_W-1:0]       gpioLive;
   logic [spfs_pkg::HOST_PADS-1:0]    hostAltOut;
   logic [spfs_pkg::HOST_PADS-1:0]    hostAltOe;
   logic [spfs_pkg::HOST_PADS-1:0]    hostAltIn;
   logic [spfs_pkg::SP0_PADS-1:0]     sp0AltIn;
   logic [spfs_pkg::SP1_PADS-1:0]     sp1AltIn;
   logic                              tmr0AltIn;
   logic                              tmr1AltIn;
   logic                              clkGpioIn;
   logic                              unusedClkPri;

   // Reset release through two flip-flops; the asynchronous edge only clears.
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) rstPipe_q <= 2'b00;
      else rstPipe_q <= {rstPipe_q[0], 1'b1};
   end
   assign rstSync_b = rstPipe_q[1];

   // Straps are taken once at the first edge after release and never again.
   always_ff @(posedge ref_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         strapDone_q <= 1'b0;
         strap_q     <= {spfs_pkg::HOSTEN_RST, spfs_pkg::ENDC_RST, spfs_pkg::ENDM_RST};
      end else if (!strapDone_q) begin
         strapDone_q <= 1'b1;
         strap_q     <= {host_enable_strap_pad, endian_correction_strap, endian_mode_strap};
      end
   end

   // One wait cycle per access lets read data come from a flip-flop.
   assign busReq          = avs_read | avs_write;
   assign avs_waitrequest = busReq & ~ack_q;
   assign wrTake          = avs_write & ack_q;
   assign avs_readdata    = rdData_q;

   always_comb begin
      beMask = 32'h0000_0000;
      for (int b = 0; b < 4; b++) begin
         beMask[b*8 +: 8] = {8{avs_byteenable[b]}};
      end
   end

   assign wrMerged = (rdMux & ~beMask) | (avs_writedata & beMask);

   // Unmapped offsets read as zero; reserved bits read as zero.
   assign rdMux =
      (avs_address == spfs_pkg::OFS_DEVICE_CONFIGURATION_REGISTER) ? {27'h0000000, device_configuration_register_q} :
      (avs_address == spfs_pkg::OFS_GPIO_ENABLE_REGISTER)   ? {16'h0000, gpio_enable_register_q} :
      (avs_address == spfs_pkg::OFS_GPIO_DIRECTION_REGISTER)  ? {16'h0000, gpio_direction_register_q} :
      (avs_address == spfs_pkg::OFS_BUSCTL) ? {31'h00000000, clock_output2_enable_q} :
      (avs_address == spfs_pkg::OFS_APDIR0) ? {17'h00000, apdir0_q} :
      (avs_address == spfs_pkg::OFS_APDIR1) ? {17'h00000, apdir1_q} :
      (avs_address == spfs_pkg::OFS_MUTE)   ? {28'h0000000, mute_q} :
      (avs_address == spfs_pkg::OFS_STATUS) ? {28'h0000000, bigEndianLaneSel, strap_q} :
      32'h0000_0000;

   always_ff @(posedge ref_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         ack_q    <= 1'b0;
         rdData_q <= 32'h0000_0000;
      end else begin
         ack_q    <= busReq & ~ack_q;
         rdData_q <= (avs_read & ~ack_q) ? rdMux : rdData_q;
      end
   end

   // Registers change at the accepting edge and steer the pads from then on.
   always_ff @(posedge ref_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         device_configuration_register_q <= spfs_pkg::DEVICE_CONFIGURATION_REGISTER_RST;
         gpio_enable_register_q   <= spfs_pkg::GPIO_ENABLE_REGISTER_RST;
         gpio_direction_register_q  <= spfs_pkg::GPIO_DIRECTION_REGISTER_RST;
         clock_output2_enable_q <= spfs_pkg::CLOCK_OUTPUT2_ENABLE_RST;
         apdir0_q <= spfs_pkg::APDIR_RST;
         apdir1_q <= spfs_pkg::APDIR_RST;
         mute_q   <= spfs_pkg::MUTE_RST;
      end else if (wrTake) begin
         case (avs_address)
            spfs_pkg::OFS_DEVICE_CONFIGURATION_REGISTER: device_configuration_register_q <= wrMerged[spfs_pkg::DEVICE_CONFIGURATION_REGISTER_W-1:0];
            spfs_pkg::OFS_GPIO_ENABLE_REGISTER:   gpio_enable_register_q   <= wrMerged[spfs_pkg::GPIO_W-1:0];
            spfs_pkg::OFS_GPIO_DIRECTION_REGISTER:  gpio_direction_register_q  <= wrMerged[spfs_pkg::GPIO_W-1:0];
            spfs_pkg::OFS_BUSCTL: clock_output2_enable_q <= wrMerged[0];
            spfs_pkg::OFS_APDIR0: apdir0_q <= wrMerged[spfs_pkg::APIN_W-1:0];
            spfs_pkg::OFS_APDIR1: apdir1_q <= wrMerged[spfs_pkg::APIN_W-1:0];
            spfs_pkg::OFS_MUTE:   mute_q   <= wrMerged[spfs_pkg::MUTE_W-1:0];
            default: ;
         endcase
      end
   end

   // Half-rate clock for the clock output pad.
   always_ff @(posedge ref_clk or negedge rstSync_b) begin
      if (!rstSync_b) clkDiv_q <= 1'b0;
      else clkDiv_q <= ~clkDiv_q;
   end

   // A GPIO pin only drives when enabled and set as output.
   assign gpioLive = gpio_enable_register_q & gpio_direction_register_q;

   // Host-shared pads: audio port 1 first, then the eleven GPIO pins.
   genvar i;
   generate
      for (i = 0; i < spfs_pkg::HOST_PADS; i++) begin : g_host
         if (i < spfs_pkg::ASP1_PADS) begin : g_asp
            assign hostAltOut[i] = asp1Out[i];
            assign hostAltOe[i]  = apdir1_q[i];
            assign asp1In[i]     = hostAltIn[i];
         end else begin : g_gpio
            assign hostAltOut[i] = gpioOut[spfs_pkg::HOST_GPIO_IDX[i-spfs_pkg::ASP1_PADS]];
            assign hostAltOe[i]  = gpioLive[spfs_pkg::HOST_GPIO_IDX[i-spfs_pkg::ASP1_PADS]];
         end
         spfs_pad_sel u_pad (
            .selAlt (~strap_q.hostEnable),
            .priOut (hostOut[i]),
            .priOe  (hostOe[i]),
            .priIn  (hostIn[i]),
            .altOut (hostAltOut[i]),
            .altOe  (hostAltOe[i]),
            .altIn  (hostAltIn[i]),
            .padIn  (hostPadIn[i]),
            .pad    (hostPad[i])
         );
      end
      for (i = 0; i < spfs_pkg::SP0_PADS; i++) begin : g_sp0
         spfs_pad_sel u_pad (
            .selAlt (device_configuration_register_q.sp0Disable),
            .priOut (bsp0Out[i]),
            .priOe  (bsp0Oe[i]),
            .priIn  (bsp0In[i]),
            .altOut (asp0Out[spfs_pkg::SP0_ASP_IDX[i]]),
            .altOe  (apdir0_q[spfs_pkg::SP0_ASP_IDX[i]]),
            .altIn  (sp0AltIn[i]),
            .padIn  (sp0PadIn[i]),
            .pad    (sp0Pad[i])
         );
      end
      for (i = 0; i < spfs_pkg::SP1_PADS; i++) begin : g_sp1
         // I2C pads are open drain: they only ever pull low.
         spfs_pad_sel u_pad (
            .selAlt (device_configuration_register_q.sp1Disable),
            .priOut (bsp1Out[i]),
            .priOe  (bsp1Oe[i]),
            .priIn  (bsp1In[i]),
            .altOut ((i < 2) ? 1'b0 : asp0Out[spfs_pkg::SP1_ASP_IDX[i]]),
            .altOe  ((i < 2) ? i2c1DriveLow[i%2] : apdir0_q[spfs_pkg::SP1_ASP_IDX[i]]),
            .altIn  (sp1AltIn[i]),
            .padIn  (sp1PadIn[i]),
            .pad    (sp1Pad[i])
         );
      end
   endgenerate
   assign i2c1In = sp1AltIn[1:0];

   spfs_pad_sel u_tmr0_out (
      .selAlt (device_configuration_register_q.timer0Sel),
      .priOut (timer0Out),
      .priOe  (1'b1),
      .priIn  (),
      .altOut (asp0Out[2]),
      .altOe  (apdir0_q[2]),
      .altIn  (tmr0AltIn),
      .padIn  (tmr0OutPadIn),
      .pad    (tmr0OutPad)
   );

   spfs_pad_sel u_tmr1_out (
      .selAlt (device_configuration_register_q.timer1Sel),
      .priOut (timer1Out),
      .priOe  (1'b1),
      .priIn  (),
      .altOut (asp0Out[4]),
      .altOe  (apdir0_q[4]),
      .altIn  (tmr1AltIn),
      .padIn  (tmr1OutPadIn),
      .pad    (tmr1OutPad)
   );

   spfs_pad_sel u_clk (
      .selAlt (gpio_enable_register_q[spfs_pkg::GPIO_CLK_PIN]),
      .priOut (clock_output2_enable_q ? clkDiv_q : 1'b1),
      .priOe  (1'b1),
      .priIn  (unusedClkPri),
      .altOut (gpioOut[spfs_pkg::GPIO_CLK_PIN]),
      .altOe  (gpioLive[spfs_pkg::GPIO_CLK_PIN]),
      .altIn  (clkGpioIn),
      .padIn  (clkPadIn),
      .pad    (clkPad)
   );

   // Timer input pads stay shared inputs until the audio port turns them round.
   assign tmr0InPad = '{out: asp0Out[3], oe: apdir0_q[3]};
   assign tmr1InPad = '{out: asp0Out[spfs_pkg::APIN_TXHCLK],
                        oe: apdir0_q[spfs_pkg::APIN_TXHCLK]};
   assign timer0In  = apdir0_q[3] ? 1'b0 : tmr0InPadIn;
   assign timer1In  = apdir0_q[spfs_pkg::APIN_TXHCLK] ? 1'b0 : tmr1InPadIn;

   // Audio port 0 collects each pin from the one pad that carries it.
   always_comb begin
      asp0In = '0;
      for (int k = 0; k < spfs_pkg::SP0_PADS; k++) begin
         asp0In[spfs_pkg::SP0_ASP_IDX[k]] = sp0AltIn[k];
      end
      for (int k = 2; k < spfs_pkg::SP1_PADS; k++) begin
         asp0In[spfs_pkg::SP1_ASP_IDX[k]] = sp1AltIn[k];
      end
      asp0In[2]                    = tmr0AltIn;
      asp0In[4]                    = tmr1AltIn;
      asp0In[3]                    = tmr0InPadIn;
      asp0In[spfs_pkg::APIN_TXHCLK] = tmr1InPadIn;
   end

   // GPIO inputs: host-shared pins only while released by the strap.
   always_comb begin
      gpioIn = '0;
      for (int k = 0; k < 11; k++) begin
         gpioIn[spfs_pkg::HOST_GPIO_IDX[k]] = hostAltIn[spfs_pkg::ASP1_PADS + k]
                                              & gpio_enable_register_q[spfs_pkg::HOST_GPIO_IDX[k]];
      end
      gpioIn[spfs_pkg::GPIO_CLK_PIN] = clkGpioIn;
   end

   // Mute inputs follow the enable and polarity that software sets up.
   assign asp0MuteIn = mute_q[spfs_pkg::MUTE_EN0] & ~gpio_direction_register_q[spfs_pkg::GPIO_MUTE0_PIN]
                       & (gp5PadIn ^ mute_q[spfs_pkg::MUTE_POL0]);
   assign asp1MuteIn = mute_q[spfs_pkg::MUTE_EN1] & ~gpio_direction_register_q[spfs_pkg::GPIO_MUTE1_PIN]
                       & (gp4PadIn ^ mute_q[spfs_pkg::MUTE_POL1]);

   // Lane correction applies only in big endian mode with the strap set.
   assign bigEndianLaneSel = strap_q.endianCorr & ~strap_q.endianMode;
   assign memBusClkSrc     = device_configuration_register_q.memBusClkSrc;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstSync_b);

   sequence devcfgWrite;
      wrTake && (avs_address == spfs_pkg::OFS_DEVICE_CONFIGURATION_REGISTER) && avs_byteenable[0];
   endsequence
   sequence accessStart;
      busReq && !ack_q;
   endsequence

   chk_host_owns: assert property (strap_q.hostEnable |-> hostPad[0].oe == hostOe[0]
      && hostPad[20].out == hostOut[20] && hostAltIn == '0)
      else $error("host pads not owned by host port");
   chk_asp1_owns: assert property (!strap_q.hostEnable |-> hostPad[3].oe == apdir1_q[3]
      && hostIn == '0)
      else $error("audio port 1 pad ownership wrong");
   chk_strap_hold: assert property (strapDone_q |=> $stable(strap_q))
      else $error("strap selection changed after reset");
   chk_clk_held: assert property (!gpio_enable_register_q[2] && !clock_output2_enable_q |-> clkPad.out && clkPad.oe)
      else $error("clock pad not held high");
   chk_clk_toggle: assert property (!gpio_enable_register_q[2] && clock_output2_enable_q ##1 !gpio_enable_register_q[2] && clock_output2_enable_q
      |-> clkPad.out != $past(clkPad.out))
      else $error("clock pad not toggling");
   chk_sp0_route: assert property (device_configuration_register_q.sp0Disable |-> sp0Pad[1].oe == apdir0_q[0]
      && bsp0In == '0)
      else $error("serial port 0 pads misrouted");
   chk_sp1_route: assert property (!device_configuration_register_q.sp1Disable |-> sp1Pad[5].oe == bsp1Oe[5]
      && i2c1In == 2'b00)
      else $error("serial port 1 pads misrouted");
   chk_tmr_route: assert property (device_configuration_register_q.timer0Sel |-> tmr0OutPad.oe == apdir0_q[2])
      else $error("timer 0 output pad misrouted");
   chk_tmr1_route: assert property (!device_configuration_register_q.timer1Sel |-> tmr1OutPad.out == timer1Out
      && tmr1OutPad.oe)
      else $error("timer 1 output pad misrouted");
   chk_tin_share: assert property (!apdir0_q[3] |-> timer0In == tmr0InPadIn
      && !tmr0InPad.oe)
      else $error("timer 0 input not shared");
   chk_tin1_out: assert property (apdir0_q[8] |-> tmr1InPad.oe && !timer1In)
      else $error("timer 1 input pad not turned round");
   chk_endian_lane: assert property (bigEndianLaneSel == (strap_q.endianCorr
      && !strap_q.endianMode))
      else $error("endian lane select wrong");
   chk_cfg_write: assert property (devcfgWrite |=> device_configuration_register_q == $past(avs_writedata[4:0]))
      else $error("configuration write not applied");
   chk_one_wait: assert property (accessStart |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("access not answered after one wait");
   chk_gpio_gate: assert property (!gpio_enable_register_q[2] |-> gpioIn[2] == 1'b0)
      else $error("disabled GPIO pin passes input");

endmodule // spfs_pin_selector

// ===== spfs_pkg.sv
// Constants, register map and carrier types for the shared pin function selector.
package spfs_pkg;

   // Clock rate of ref_clk.
   localparam int unsigned CLK_HZ = 20_000_000;

   // Register byte offsets on the Avalon-MM slave.
   localparam logic [7:0] OFS_DEVICE_CONFIGURATION_REGISTER = 8'h00;
   localparam logic [7:0] OFS_GPIO_ENABLE_REGISTER   = 8'h04;
   localparam logic [7:0] OFS_GPIO_DIRECTION_REGISTER  = 8'h08;
   localparam logic [7:0] OFS_BUSCTL = 8'h0c;
   localparam logic [7:0] OFS_APDIR0 = 8'h10;
   localparam logic [7:0] OFS_APDIR1 = 8'h14;
   localparam logic [7:0] OFS_MUTE   = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1c;

   // Widths and pad counts.
   localparam int DEVICE_CONFIGURATION_REGISTER_W  = 5;
   localparam int GPIO_W    = 16;
   localparam int APIN_W    = 15;
   localparam int MUTE_W    = 4;
   localparam int HOST_PADS = 26;
   localparam int ASP1_PADS = 15;
   localparam int SP0_PADS  = 7;
   localparam int SP1_PADS  = 6;

   // Values after reset.
   localparam logic [DEVICE_CONFIGURATION_REGISTER_W-1:0] DEVICE_CONFIGURATION_REGISTER_RST = 5'h00;
   localparam logic [GPIO_W-1:0]   GPIO_ENABLE_REGISTER_RST   = 16'h0000;
   localparam logic [GPIO_W-1:0]   GPIO_DIRECTION_REGISTER_RST  = 16'h0000;
   localparam logic                CLOCK_OUTPUT2_ENABLE_RST = 1'b1;
   localparam logic [APIN_W-1:0]   APDIR_RST  = 15'h0000;
   localparam logic [MUTE_W-1:0]   MUTE_RST   = 4'h0;
   localparam logic                HOSTEN_RST = 1'b1;
   localparam logic                ENDC_RST   = 1'b1;
   localparam logic                ENDM_RST   = 1'b1;

   // Audio port pin indices, shared by pin direction registers and pin vectors.
   localparam int APIN_TXHCLK = 8;
   localparam int APIN_RXHCLK = 9;
   localparam int APIN_TXCLK  = 10;
   localparam int APIN_RXCLK  = 11;
   localparam int APIN_TXFS   = 12;
   localparam int APIN_RXFS   = 13;
   localparam int APIN_MUTE   = 14;

   // Field positions.
   localparam int GPIO_CLK_PIN   = 2;
   localparam int GPIO_MUTE0_PIN = 5;
   localparam int GPIO_MUTE1_PIN = 4;
   localparam int MUTE_EN0       = 0;
   localparam int MUTE_POL0      = 1;
   localparam int MUTE_EN1       = 2;
   localparam int MUTE_POL1      = 3;

   // Host pad i >= ASP1_PADS carries this GPIO pin.
   localparam int HOST_GPIO_IDX [0:10] = '{0, 1, 3, 8, 9, 10, 11, 12, 13, 14, 15};
   // Audio port 0 pin on each serial port 0 pad.
   localparam int SP0_ASP_IDX [0:6] = '{APIN_RXHCLK, 0, 1, APIN_RXFS, APIN_TXFS,
                                        APIN_RXCLK, APIN_TXCLK};
   // Audio port 0 pin on serial port 1 pads 2 to 5; pads 0 and 1 carry I2C.
   localparam int SP1_ASP_IDX [0:5] = '{0, 0, 5, 7, 6, APIN_MUTE};

   typedef struct packed {
      logic memBusClkSrc;
      logic timer1Sel;
      logic timer0Sel;
      logic sp0Disable;
      logic sp1Disable;
   } spfs_device_configuration_register_s;

   typedef struct packed {
      logic out;
      logic oe;
   } spfs_pad_s;

   typedef struct packed {
      logic hostEnable;
      logic endianCorr;
      logic endianMode;
   } spfs_strap_s;

endpackage

// ===== testbench.sv
// Self-checking bench for the shared pin function selector.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        hostStrap = 1'b1;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [63:0] rnd = 64'h0;
   logic [31:0] rdat;
   logic        wreq, laneSel, t0In;
   logic        m0, m1;
   logic [25:0] hostIn;
   logic [6:0]  b0In;
   spfs_pkg::spfs_pad_s [25:0] hp;
   spfs_pkg::spfs_pad_s [6:0]  s0;
   spfs_pkg::spfs_pad_s [5:0]  s1;
   spfs_pkg::spfs_pad_s        ck, o0, o1, i0, i1;
   wire [14:0]  a0 = rnd[29:15];
   logic [31:0] expQ[$];
   int          nErrors = 0;
   int          compares = 0;
   int          seed = 32'hbdb0;

   spfs_pin_selector dut (.ref_clk(ref_clk), .rst_b(rst_b), .host_enable_strap_pad(hostStrap),
      .endian_correction_strap(1'b1), .endian_mode_strap(1'b0), .avs_address(adr),
      .avs_read(rd), .avs_write(wr), .avs_writedata(wdat), .avs_byteenable(4'hf),
      .avs_readdata(rdat), .avs_waitrequest(wreq), .hostPadIn(rnd[25:0]), .hostPad(hp),
      .hostOut(rnd[51:26]), .hostOe(rnd[63:38]), .hostIn(hostIn), .asp1Out(rnd[14:0]),
      .asp1In(), .asp0Out(a0), .asp0In(), .asp0MuteIn(m0), .asp1MuteIn(m1),
      .gpioOut(rnd[47:32]), .gpioIn(), .gp4PadIn(rnd[0]), .gp5PadIn(rnd[1]),
      .clkPadIn(rnd[2]), .clkPad(ck), .sp0PadIn(rnd[9:3]), .sp0Pad(s0), .bsp0Out(rnd[16:10]),
      .bsp0Oe(rnd[23:17]), .bsp0In(b0In), .sp1PadIn(rnd[29:24]), .sp1Pad(s1),
      .bsp1Out(rnd[35:30]), .bsp1Oe(rnd[41:36]), .bsp1In(), .i2c1DriveLow(rnd[43:42]),
      .i2c1In(), .timer0Out(rnd[44]), .timer1Out(rnd[45]), .timer0In(t0In), .timer1In(),
      .tmr0OutPadIn(rnd[46]), .tmr1OutPadIn(rnd[47]), .tmr0InPadIn(rnd[48]),
      .tmr1InPadIn(rnd[49]), .tmr0OutPad(o0), .tmr1OutPad(o1), .tmr0InPad(i0),
      .tmr1InPad(i1), .bigEndianLaneSel(laneSel), .memBusClkSrc());

   initial forever #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) rnd <= {$random(seed), $random(seed)};
   // Read data is taken only at the accepting edge, against the oldest note.
   always @(posedge ref_clk) if (rd && !wreq && expQ.size() > 0) cmp(rdat, expQ.pop_front());

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         nErrors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic end_of_test;
      $display("compares %0d mismatches %0d", compares, nErrors);
      if (nErrors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, e);
      int i = 0;
      @(posedge ref_clk);
      adr <= a;
      wdat <= d;
      wr <= w;
      rd <= !w;
      if (!w) expQ.push_back(e);
      do begin
         @(negedge ref_clk);
         i++;
      end while (wreq && i < 64);
      if (wreq) begin
         nErrors++;
         end_of_test;
      end
      @(posedge ref_clk);
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   // The strap is moved after capture so a late change would show up.
   task automatic doReset(input logic s);
      @(posedge ref_clk);
      rst_b <= 1'b0;
      hostStrap <= s;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge ref_clk);
      hostStrap <= !s;
   endtask

   initial begin
      doReset(1'b1);
      bus(0, spfs_pkg::OFS_DEVICE_CONFIGURATION_REGISTER, 0, 32'h0);
      bus(0, spfs_pkg::OFS_BUSCTL, 0, 32'h1);
      bus(0, spfs_pkg::OFS_STATUS, 0, 32'he);
      bus(0, 8'h20, 0, 32'h0);
      @(negedge ref_clk);
      cmp({hp[3], laneSel}, {rnd[29], rnd[41], 1'b1});
      $display("test reset done");
      bus(1, spfs_pkg::OFS_DEVICE_CONFIGURATION_REGISTER, 32'hffffffe3, 0);
      bus(0, spfs_pkg::OFS_DEVICE_CONFIGURATION_REGISTER, 0, 32'h3);
      bus(1, spfs_pkg::OFS_APDIR0, 32'h7fff, 0);
      @(negedge ref_clk);
      cmp({s0[1], s1[2], b0In[1]}, {a0[0], 1'b1, a0[5], 1'b1, 1'b0});
      cmp({o0, o1}, {rnd[44], 1'b1, rnd[45], 1'b1});
      bus(1, spfs_pkg::OFS_DEVICE_CONFIGURATION_REGISTER, 32'hc, 0);
      @(negedge ref_clk);
      cmp({o0, o1, i0, i1, t0In}, {a0[2], 1'b1, a0[4], 1'b1, a0[3], 1'b1, a0[8], 2'b10});
      cmp(s0[1], {rnd[11], rnd[18]});
      $display("test serial done");
      bus(1, spfs_pkg::OFS_BUSCTL, 0, 0);
      repeat (3) begin
         @(negedge ref_clk);
         cmp(ck, 2'b11);
      end
      bus(1, spfs_pkg::OFS_GPIO_ENABLE_REGISTER, 32'h4, 0);
      @(negedge ref_clk);
      cmp(ck.oe, 1'b0);
      bus(1, spfs_pkg::OFS_GPIO_DIRECTION_REGISTER, 32'h4, 0);
      @(negedge ref_clk);
      cmp(ck, {rnd[34], 1'b1});
      $display("test clock pad done");
      doReset(1'b0);
      bus(1, spfs_pkg::OFS_GPIO_ENABLE_REGISTER, 32'h1, 0);
      bus(1, spfs_pkg::OFS_GPIO_DIRECTION_REGISTER, 32'h1, 0);
      @(negedge ref_clk);
      cmp({hp[0], hp[15], hostIn[0]}, {rnd[0], 1'b0, rnd[32], 1'b1, 1'b0});
      bus(1, spfs_pkg::OFS_APDIR1, 32'h1, 0);
      @(negedge ref_clk);
      cmp(hp[0], {rnd[0], 1'b1});
      bus(0, spfs_pkg::OFS_STATUS, 0, 32'ha);
      $display("test strap low done");
      // Pins 5 and 4 stay inputs; port 0 mute inverted, port 1 mute straight.
      bus(1, spfs_pkg::OFS_MUTE, 32'h7, 0);
      @(negedge ref_clk);
      cmp({m0, m1}, {~rnd[1], rnd[0]});
      bus(1, spfs_pkg::OFS_GPIO_DIRECTION_REGISTER, 32'h21, 0);
      @(negedge ref_clk);
      cmp({m0, m1}, {1'b0, rnd[0]});
      $display("test mute input done");
      end_of_test;
   end
endmodule // testbench
